// file: core/api_pkg.sv
// Constants and types shared by the axis pulse and pin logic.
// Assumes a 10 MHz system clock; all times are converted to cycle counts here.
package api_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
  // Step output timing
  localparam int unsigned STEP_MAX_HZ   = 12_500;
  localparam int unsigned STEP_HIGH_US  = 39;
  localparam int unsigned STEP_PER_CYC  = CLK_HZ / STEP_MAX_HZ;
  localparam int unsigned STEP_HIGH_CYC = (STEP_HIGH_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GUARD_US      = 20;
  localparam int unsigned GUARD_CYC     = (GUARD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W         = 12;
  // Position counter width
  localparam int unsigned POS_W         = 32;
  // Stored-settings command code
  localparam logic [7:0]  STORE_SETTINGS_CMD = 8'h1f;
  // Reset values
  localparam logic [3:0]  OUT_PORT_RST  = 4'h0;
  localparam logic [1:0]  INV_RST       = 2'h0;
  // Input 2/3 and input 1 function codes
  localparam logic        IN23_STOP     = 1'b0;
  localparam logic        IN23_JOG      = 1'b1;
  localparam logic        IN1_PLAIN     = 1'b0;
  localparam logic        IN1_STOP      = 1'b1;
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_HIGH, ST_TRAIL} api_step_t;
endpackage

// file: core/api_sync.sv
// Two-stage synchroniser bank for pin inputs.
// Assumes inputs are asynchronous to i_clk; output is usable after two edges.
`timescale 1ns/10ps
module api_sync #(
  parameter int unsigned W = 1
) (
  // Clock
  input  wire logic         i_clk,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk) begin
        meta[g]   <= i_async[g];
        o_sync[g] <= meta[g];
      end
    end
  endgenerate
endmodule // api_sync

// file: core/api_axis_pulse_io.sv
// Pin-level logic of one motion axis: step/direction, encoder counter,
// sensor and general-purpose I/O. Assumes external pull resistors hold pins in reset.
`timescale 1ns/10ps
module api_axis_pulse_io (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  // Motion requests from the axis controller
  input  wire logic             i_step_req,
  input  wire logic             i_step_neg,
  input  wire logic             i_axis_busy,
  input  wire logic             i_origin_search3,
  input  wire logic             i_wdt_out,
  input  wire logic             i_wdt_enable,
  // Settings
  input  wire logic             i_flip_direction_bit,
  input  wire logic             i_busy_to_out2_select,
  input  wire logic             i_gate_on_out3_bit,
  input  wire logic             i_flip_out012_bit,
  input  wire logic             i_flip_out3_bit,
  input  wire logic             i_flip_encoder_dir_bit,
  input  wire logic             i_in23_function_select,
  input  wire logic             i_in1_function_select,
  input  wire logic [3:0]       i_output_port_bits,
  input  wire logic             i_output_port_we,
  input  wire logic [7:0]       i_instruction,
  input  wire logic             i_instruction_we,
  // Stored polarity (non-volatile copy, owned outside)
  input  wire logic [1:0]       i_stored_inv,
  output logic      [1:0]       o_store_inv,
  output logic                  o_store_we,
  // Pins
  input  wire logic             i_encoder_clock_in,
  input  wire logic             i_encoder_sense_in,
  input  wire logic             i_origin_sensor_n,
  input  wire logic             i_plus_limit_n,
  input  wire logic             i_minus_limit_n,
  input  wire logic [3:0]       i_gp_in_n,
  output logic                  o_step_pulse_out,
  output logic                  o_step_pulse_oe,
  output logic                  o_direction_out,
  output logic                  o_direction_oe,
  output logic      [3:0]       o_gp_out,
  output logic      [3:0]       o_gp_out_oe,
  // Status
  output logic                  o_step_ack,
  output logic                  o_step_blocked,
  output logic      [api_pkg::POS_W-1:0] o_position,
  output logic      [3:0]       o_input_monitor_bits,
  output logic                  o_origin,
  output logic                  o_plus_limit,
  output logic                  o_minus_limit,
  output logic                  o_encoder_zero,
  output logic                  o_stop_in,
  output logic                  o_plus_stop,
  output logic                  o_minus_stop,
  output logic                  o_jog_plus,
  output logic                  o_jog_minus
);
  import api_pkg::*;

  // Synchronised pins
  logic [8:0] pins_s;
  api_sync #(.W(9)) u_sync (
    .i_clk   (i_clk),
    .i_async ({i_gp_in_n, i_minus_limit_n, i_plus_limit_n, i_origin_sensor_n,
               i_encoder_sense_in, i_encoder_clock_in}),
    .o_sync  (pins_s)
  );
  logic       enc_clk_s;
  logic       enc_sense_s;
  logic       enc_clk_d;
  logic [3:0] gp_in_s;
  assign enc_clk_s   = pins_s[0];
  assign enc_sense_s = pins_s[1];
  assign gp_in_s     = pins_s[8:5];

  // Settings and output state
  logic [3:0] out_port;
  logic [1:0] inv_pwr;
  logic       pwr_up;
  api_step_t  state;
  logic [CNT_W-1:0] cnt;
  logic       dir_logic;
  logic       out2_logic;
  logic       out3_logic;
  logic [3:0] next_gp;
  logic       next_dir;
  logic       frozen;
  logic       gate_ok;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      out_port <= OUT_PORT_RST;
    end else if (i_output_port_we) begin
      out_port <= i_output_port_bits;
    end
  end

  // Stored polarity is captured after reset release, never under reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pwr_up  <= 1'b1;
      inv_pwr <= INV_RST;
    end else if (pwr_up) begin
      pwr_up  <= 1'b0;
      inv_pwr <= i_stored_inv;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_store_we  <= 1'b0;
      o_store_inv <= INV_RST;
    end else begin
      o_store_we  <= i_instruction_we && i_instruction == STORE_SETTINGS_CMD;
      o_store_inv <= {i_flip_out3_bit, i_flip_out012_bit};
    end
  end

  // Until the next reset, the stored polarity is ORed with the settings' polarity bits at the pins
  logic inv012;
  logic inv3;
  assign inv012 = pwr_up ? 1'b0 : (i_flip_out012_bit | inv_pwr[0]);
  assign inv3   = pwr_up ? 1'b0 : (i_flip_out3_bit | inv_pwr[1]);

  assign out3_logic = i_wdt_enable ? i_wdt_out : out_port[3];
  assign out2_logic = i_busy_to_out2_select ? i_axis_busy : out_port[2];
  assign dir_logic  = i_step_neg ^ i_flip_direction_bit;
  assign gate_ok    = !i_gate_on_out3_bit || out3_logic;
  assign frozen     = state != ST_IDLE;

  always_comb begin
    next_gp[0] = out_port[0] ^ inv012;
    next_gp[1] = out_port[1] ^ inv012;
    next_gp[2] = out2_logic ^ inv012;
    next_gp[3] = out3_logic ^ inv3;
    next_dir   = dir_logic;
  end

  // Step sequencer: lead guard, high phase, trail guard
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= '0;
          if (i_step_req && gate_ok) begin
            state <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (cnt == CNT_W'(GUARD_CYC - 1)) begin
            state <= ST_HIGH;
            cnt   <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_HIGH: begin
          if (cnt == CNT_W'(STEP_HIGH_CYC - 1)) begin
            state <= ST_TRAIL;
            cnt   <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_TRAIL: begin
          // Trail lasts long enough that the full period meets the rate limit
          if (cnt == CNT_W'(STEP_PER_CYC - STEP_HIGH_CYC - GUARD_CYC - 1)) begin
            state <= ST_IDLE;
            cnt   <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          cnt   <= '0;
        end
      endcase
    end
  end

  // Pin drivers; enables low under reset so the pins float
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_step_pulse_out <= 1'b0;
      o_step_pulse_oe  <= 1'b0;
      o_direction_out  <= 1'b0;
      o_direction_oe   <= 1'b0;
      o_gp_out         <= 4'h0;
      o_gp_out_oe      <= 4'h0;
    end else begin
      o_step_pulse_oe  <= 1'b1;
      o_direction_oe   <= 1'b1;
      // Held floating one more edge so no pin shows the unstored level, except outputs 2/3 while a step taken on the first edge runs
      o_gp_out_oe      <= {4{!pwr_up}};
      o_step_pulse_out <= state == ST_HIGH;
      if (!frozen) begin
        o_direction_out <= next_dir;
        o_gp_out[3:2]   <= next_gp[3:2];
      end
      o_gp_out[1:0] <= next_gp[1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_step_ack     <= 1'b0;
      o_step_blocked <= 1'b0;
    end else begin
      o_step_ack     <= state == ST_IDLE && i_step_req && gate_ok;
      o_step_blocked <= i_step_req && !gate_ok;
    end
  end

  // Encoder position counter
  logic enc_up;
  assign enc_up = enc_sense_s == i_flip_encoder_dir_bit;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      enc_clk_d  <= 1'b0;
      o_position <= '0;
    end else begin
      enc_clk_d <= enc_clk_s;
      if (enc_clk_s && !enc_clk_d) begin
        o_position <= enc_up ? o_position + 1'b1 : o_position - 1'b1;
      end
    end
  end

  // Sensors and shared input functions, all low-active
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_input_monitor_bits <= 4'h0;
      o_origin       <= 1'b0;
      o_plus_limit   <= 1'b0;
      o_minus_limit  <= 1'b0;
      o_encoder_zero <= 1'b0;
      o_stop_in      <= 1'b0;
      o_plus_stop    <= 1'b0;
      o_minus_stop   <= 1'b0;
      o_jog_plus     <= 1'b0;
      o_jog_minus    <= 1'b0;
    end else begin
      o_input_monitor_bits <= ~gp_in_s;
      o_origin       <= !pins_s[2];
      o_plus_limit   <= !pins_s[3];
      o_minus_limit  <= !pins_s[4];
      o_encoder_zero <= i_origin_search3 && !gp_in_s[0];
      o_stop_in      <= i_in1_function_select == IN1_STOP && !gp_in_s[1];
      o_plus_stop    <= i_in23_function_select == IN23_STOP && !gp_in_s[2];
      o_minus_stop   <= i_in23_function_select == IN23_STOP && !gp_in_s[3];
      o_jog_plus     <= i_in23_function_select == IN23_JOG && !gp_in_s[2];
      o_jog_minus    <= i_in23_function_select == IN23_JOG && !gp_in_s[3];
    end
  end

  // Step timing counters for the checks; the gap saturates so idle time cannot wrap
  logic [CNT_W-1:0] high_run;
  logic [CNT_W-1:0] step_gap;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      high_run <= '0;
    end else if (o_step_pulse_out) begin
      high_run <= high_run + 1'b1;
    end else begin
      high_run <= '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      step_gap <= CNT_W'(STEP_PER_CYC);
    end else if (o_step_pulse_out && high_run == '0) begin
      step_gap <= CNT_W'(1);
    end else if (step_gap != '1) begin
      step_gap <= step_gap + 1'b1;
    end
  end

  // Assertions
  chk_step_idle_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
    state == ST_IDLE && $past(state) == ST_IDLE |-> !o_step_pulse_out)
    else $error("step output high while idle");
  chk_reset_float: assert property (@(posedge i_clk)
    !$past(i_resetn) |-> !o_step_pulse_oe && !o_direction_oe)
    else $error("step or direction driven in reset");
  chk_step_width: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(o_step_pulse_out) |-> high_run >= CNT_W'(STEP_HIGH_CYC))
    else $error("step high phase too short");
  chk_step_rate: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_step_pulse_out && high_run == '0 |-> step_gap >= CNT_W'(STEP_PER_CYC))
    else $error("step rate above limit");
  chk_dir_level: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $past(state) == ST_IDLE && state == ST_IDLE && $past(state,2) == ST_IDLE
      && $stable(i_step_neg) && $stable(i_flip_direction_bit)
      && $past(i_resetn) |-> o_direction_out == ($past(i_step_neg) ^ $past(i_flip_direction_bit)))
    else $error("direction level wrong");
  chk_dir_frozen: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $past(state) != ST_IDLE && $past(i_resetn) |-> $stable(o_direction_out) && $stable(o_gp_out[3:2]))
    else $error("direction or outputs 2/3 moved around a step");
  chk_gate_block: assert property (@(posedge i_clk) disable iff (!i_resetn)
    state == ST_IDLE && i_gate_on_out3_bit && !out3_logic |=> state == ST_IDLE)
    else $error("axis moved with output 3 inactive");
  chk_gp_float: assert property (@(posedge i_clk)
    !$past(i_resetn) |-> o_gp_out_oe == 4'h0)
    else $error("general outputs driven in reset");
  chk_enc_count: assert property (@(posedge i_clk) disable iff (!i_resetn)
    enc_clk_s && !enc_clk_d && !enc_up |=> o_position == $past(o_position) - 1'b1)
    else $error("encoder down count wrong");
  chk_monitor: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $past(i_resetn) |-> o_input_monitor_bits == ~$past(gp_in_s))
    else $error("input monitor wrong");
  chk_port_reset: assert property (@(posedge i_clk)
    !$past(i_resetn) |-> out_port == 4'h0)
    else $error("output port bits not cleared");

  cov_step: cover property (@(posedge i_clk) disable iff (!i_resetn) $fell(o_step_pulse_out));
  cov_enc_up: cover property (@(posedge i_clk) disable iff (!i_resetn)
    enc_clk_s && !enc_clk_d && enc_up);
  cov_store: cover property (@(posedge i_clk) disable iff (!i_resetn) o_store_we);
  cov_blocked: cover property (@(posedge i_clk) disable iff (!i_resetn) o_step_blocked);
endmodule // api_axis_pulse_io

// file: bench/api_far_side.sv
// Far side of the axis: encoder source, sensor circuits, step pin load.
// Assumes the bench drives i_go 10 ns after an edge; this model acts at 5 ns.
`timescale 1ns/10ps
module api_far_side (
  // Clock
  input  wire logic       i_clk,
  // Encoder burst control
  input  wire logic       i_go,
  input  wire logic       i_dir,
  input  wire logic [2:0] i_count,
  output logic            o_busy,
  // Sensor levels wanted, active high
  input  wire logic [2:0] i_sense_on,
  // Step pin with its pull-down
  input  wire logic       i_step,
  input  wire logic       i_step_oe,
  output logic            o_step_wire,
  // Pins toward the design
  output logic            o_enc_clk,
  output logic            o_enc_sense,
  output logic [2:0]      o_sensor_n
);
  localparam int PHASE = 400;
  assign o_sensor_n  = ~i_sense_on;
  assign o_step_wire = i_step_oe ? i_step : 1'h0;
  initial begin
    o_busy = 1'h0;
    o_enc_clk = 1'h0;
    o_enc_sense = 1'h0;
  end
  always begin
    @(posedge i_clk);
    #5;
    if (i_go) begin
      o_busy = 1'h1;
      o_enc_sense = i_dir;
      repeat (i_count) begin
        repeat (PHASE) @(posedge i_clk);
        #5 o_enc_clk = 1'h1;
        repeat (PHASE) @(posedge i_clk);
        #5 o_enc_clk = 1'h0;
      end
      // Sense held 80 us past the last rise
      repeat (PHASE) @(posedge i_clk);
      #5 o_busy = 1'h0;
    end else begin
      // Released line must not look held
      o_enc_sense = ~o_enc_sense;
    end
  end
endmodule // api_far_side

// file: bench/testbench.sv
// Self-checking bench for the axis pin logic with a far-side model.
// Assumes a 10 MHz clock; inputs change 10 ns after each rising edge.
`timescale 1ns/10ps
module testbench;
  import api_pkg::*;
  logic i_clk, i_resetn, i_step_req, i_step_neg, i_axis_busy, i_origin_search3, i_wdt_out;
  logic i_wdt_enable, i_flip_direction_bit, i_busy_to_out2_select, i_gate_on_out3_bit;
  logic i_flip_out012_bit, i_flip_out3_bit, i_flip_encoder_dir_bit, i_in23_function_select;
  logic i_in1_function_select, i_output_port_we, i_instruction_we, o_store_we;
  logic i_encoder_clock_in, i_encoder_sense_in, i_origin_sensor_n, i_plus_limit_n;
  logic i_minus_limit_n, o_step_pulse_out, o_step_pulse_oe, o_direction_out, o_direction_oe;
  logic o_step_ack, o_step_blocked, o_origin, o_plus_limit, o_minus_limit, o_encoder_zero;
  logic o_stop_in, o_plus_stop, o_minus_stop, o_jog_plus, o_jog_minus;
  logic go, dir, busy, step_wire, dir0;
  logic [1:0] i_stored_inv, o_store_inv;
  logic [2:0] cnt, sense_on, sensor_n;
  logic [3:0] i_output_port_bits, i_gp_in_n, o_gp_out, o_gp_out_oe, o_input_monitor_bits;
  logic [7:0] i_instruction;
  logic [POS_W-1:0] o_position;
  logic [31:0] seed = 32'h29;
  logic [31:0] r;
  int fails = 0;
  int num_checks = 0;
  int pos = 0;
  int w;
  assign {i_minus_limit_n, i_plus_limit_n, i_origin_sensor_n} = sensor_n;
  api_axis_pulse_io i_dut (
    .i_clk, .i_resetn, .i_step_req, .i_step_neg, .i_axis_busy, .i_origin_search3,
    .i_wdt_out, .i_wdt_enable, .i_flip_direction_bit, .i_busy_to_out2_select,
    .i_gate_on_out3_bit, .i_flip_out012_bit, .i_flip_out3_bit, .i_flip_encoder_dir_bit,
    .i_in23_function_select, .i_in1_function_select, .i_output_port_bits, .i_output_port_we,
    .i_instruction, .i_instruction_we, .i_stored_inv, .o_store_inv, .o_store_we,
    .i_encoder_clock_in, .i_encoder_sense_in, .i_origin_sensor_n, .i_plus_limit_n,
    .i_minus_limit_n, .i_gp_in_n, .o_step_pulse_out, .o_step_pulse_oe, .o_direction_out,
    .o_direction_oe, .o_gp_out, .o_gp_out_oe, .o_step_ack, .o_step_blocked, .o_position,
    .o_input_monitor_bits, .o_origin, .o_plus_limit, .o_minus_limit, .o_encoder_zero,
    .o_stop_in, .o_plus_stop, .o_minus_stop, .o_jog_plus, .o_jog_minus);
  api_far_side i_far (
    .i_clk, .i_go(go), .i_dir(dir), .i_count(cnt), .o_busy(busy), .i_sense_on(sense_on),
    .i_step(o_step_pulse_out), .i_step_oe(o_step_pulse_oe), .o_step_wire(step_wire),
    .o_enc_clk(i_encoder_clock_in), .o_enc_sense(i_encoder_sense_in), .o_sensor_n(sensor_n));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #10;
  endtask
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pos(input logic [POS_W-1:0] exp);
    chk_val("position", exp, o_position);
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    i_resetn = 1'h0;
    tick(2);
    chk_val("oe in reset", 6'h0, {o_step_pulse_oe, o_direction_oe, o_gp_out_oe});
    chk_val("step wire", 1'h0, step_wire);
    i_resetn = 1'h1;
    tick(3);
  endtask
  task automatic wr_port(input logic [3:0] b);
    i_output_port_bits = b;
    i_output_port_we = 1'h1;
    tick(1);
    i_output_port_we = 1'h0;
    tick(3);
  endtask
  task automatic wait_ack();
    w = 0;
    while (o_step_ack !== 1'h1 && w < 900) begin
      tick(1);
      w++;
    end
    chk_val("ack", 1'h1, o_step_ack);
  endtask
  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    fails++;
    finish_test();
  end
  initial begin
    {i_step_req, i_step_neg, i_axis_busy, i_origin_search3, i_wdt_out, i_wdt_enable} = 6'h0;
    {i_flip_direction_bit, i_busy_to_out2_select, i_gate_on_out3_bit, go, dir} = 5'h0;
    {i_flip_out012_bit, i_flip_out3_bit, i_flip_encoder_dir_bit} = 3'h0;
    {i_in23_function_select, i_in1_function_select, i_output_port_we} = 3'h0;
    {i_instruction_we, i_output_port_bits, i_instruction, i_stored_inv} = 15'h0;
    {i_gp_in_n, cnt, sense_on} = 10'h3c8;
    do_reset();
    chk_val("idle pins", 5'h0, {o_step_pulse_out, o_gp_out});
    repeat (4) begin
      r = rnd();
      {i_flip_out3_bit, i_flip_out012_bit} = r[5:4];
      wr_port(r[3:0]);
      chk_val("gp out", r[3:0] ^ {r[5], {3{r[4]}}}, o_gp_out);
    end
    repeat (6) begin
      r = rnd();
      {i_origin_search3, i_in1_function_select, i_in23_function_select} = r[9:7];
      {sense_on, i_gp_in_n} = r[6:0];
      tick(5);
      chk_val("monitor", 4'(~r[3:0]), o_input_monitor_bits);
      chk_val("sensors", r[6:4], {o_minus_limit, o_plus_limit, o_origin});
      chk_val("in23", r[7] ? {2'(~r[3:2]), 2'h0} : {2'h0, 2'(~r[3:2])},
              {o_jog_minus, o_jog_plus, o_minus_stop, o_plus_stop});
      chk_val("stop in", r[8] & ~r[1], o_stop_in);
      chk_val("enc zero", r[9] & ~r[0], o_encoder_zero);
    end
    {i_gp_in_n, sense_on, i_flip_out3_bit, i_flip_out012_bit} = 9'h1e0;
    wr_port(4'h0);
    i_busy_to_out2_select = 1'h1;
    for (int k = 0; k < 4; k++) begin
      {i_step_neg, i_flip_direction_bit, i_axis_busy} = {k[1], k[0], 1'h1};
      tick(2);
      i_step_req = 1'h1;
      wait_ack();
      i_step_req = 1'h0;
      chk_val("dir", 1'(k[0] ^ k[1]), o_direction_out);
      chk_val("busy out", 1'h1, o_gp_out[2]);
      dir0 = o_direction_out;
      {i_flip_direction_bit, i_axis_busy} = {1'(~k[0]), 1'h0};
      for (w = 1; w <= 800; w++) begin
        tick(1);
        if (w == 200 || w == 201 || w == 590 || w == 591) begin
          chk_val("step pulse", w == 201 || w == 590, o_step_pulse_out);
        end
        if (w == 1 || w == 400 || w == 790) begin
          chk_val("frozen", {dir0, 1'h1}, {o_direction_out, o_gp_out[2]});
        end
      end
      tick(3);
      chk_val("dir after", 1'(~k[0] ^ k[1]), o_direction_out);
      chk_val("busy out", 1'h0, o_gp_out[2]);
    end
    i_gate_on_out3_bit = 1'h1;
    i_step_req = 1'h1;
    tick(4);
    chk_val("gated", 2'h1, {o_step_ack, o_step_blocked});
    i_output_port_bits = 4'h8;
    i_output_port_we = 1'h1;
    tick(1);
    i_output_port_we = 1'h0;
    wait_ack();
    i_step_req = 1'h0;
    tick(800);
    {i_gate_on_out3_bit, i_wdt_enable} = 2'h1;
    for (int k = 0; k < 2; k++) begin
      i_wdt_out = k[0];
      tick(3);
      chk_val("watchdog", k[0], o_gp_out[3]);
    end
    i_wdt_enable = 1'h0;
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      {i_flip_encoder_dir_bit, dir} = {k[1], k[0]};
      cnt = r[1:0] + 3'h1;
      go = 1'h1;
      tick(1);
      go = 1'h0;
      w = 0;
      while (busy === 1'h1 && w < 5000) begin
        tick(1);
        w++;
      end
      tick(5);
      pos += (k[0] ^ k[1]) ? -int'(cnt) : int'(cnt);
      chk_pos(pos);
    end
    {i_flip_out3_bit, i_flip_out012_bit, i_instruction_we, i_instruction} = 11'h71e;
    w = 0;
    for (int k = 0; k < 6; k++) begin
      tick(1);
      if (o_store_we === 1'h1) begin
        w++;
        i_stored_inv = o_store_inv;
      end
      if (k == 0) i_instruction = STORE_SETTINGS_CMD;
      if (k == 1) i_instruction_we = 1'h0;
    end
    chk_val("store pulses", 1, w);
    chk_val("stored flips", 2'h3, i_stored_inv);
    {i_flip_out3_bit, i_flip_out012_bit} = 2'h0;
    do_reset();
    chk_val("power-up level", 4'hf, o_gp_out);
    finish_test();
  end
endmodule // testbench
